// ### hdl/clie_top.sv
/*
  Instruction executor of a character display controller: host byte bus,
  command decode, text/glyph/symbol memories, cursor and display shift.
  Assumes host pins asynchronous to ref_clk (200 MHz), strobe rising edge
  marks one transfer, and data held stable around the strobe.
*/
// Functional notes
// - clear: spaces, address zero, increment mode
// - home: address zero, shift cancelled
// - step direction sets address step sign
// - display follows only on text writes
// - display off blanks, memory kept
// - cursor shown; blink alternates all dots
// - shift moves cursor or display
// - two-line cursor wraps into line two
// - display shift leaves address and memory
// - width bit picks 8 or nibble bus
// - tall one-line text limited to 27H
// - strap high forces normal font
// - page bit picks instruction set
// - glyph address set routes data there
// - text address ranges per line mode
// - status gives busy and address
// - every data access steps address
// - data write goes to selected memory
// - first read without address set invalid
// - bias bit ignored under external bias
// - function set layout, test bit zero
// - top bit set means text address
// - entry mode layout on low bits
// - shift/glyph page zero, bias/symbol page one
`timescale 1ns/1ps
`include "clie_defs.svh"
module clie_top #(
  parameter int unsigned EXEC_CYC = (`CLIE_T_EXEC_NS + `CLIE_CLK_NS - 1) / `CLIE_CLK_NS,
  parameter int unsigned CLEAR_CYC = (`CLIE_T_CLEAR_NS + `CLIE_CLK_NS - 1) / `CLIE_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_strobe,
  input wire logic register_select_line,
  input wire logic bus_read,
  input wire logic [7:0] bus_din,
  input wire logic instruction_set_strap,
  input wire logic follower_option_a,
  input wire logic follower_option_b,
  output logic [7:0] bus_dout_q,
  output logic bus_dout_oe_q,
  output logic busy_indicator_q,
  output logic [6:0] address_counter_q,
  output logic [5:0] display_shift_q,
  output logic panel_on_q,
  output logic cursor_show_q,
  output logic cursor_all_dots_q,
  output logic bus_width_select_q,
  output logic two_line_q,
  output logic tall_font_q,
  output logic instruction_page_select_q,
  output logic bias_quarter_q,
  output logic entry_inc_q
);
  clie_sync_if #(.W(14)) pins ();
  logic s_strobe, s_rs, s_rd, s_strap, s_opt_a, s_opt_b;
  logic [7:0] s_din;

  // all host pins and straps pass two flops
  assign pins.raw = {bus_strobe, register_select_line, bus_read, bus_din,
                     instruction_set_strap, follower_option_a, follower_option_b};
  assign {s_strobe, s_rs, s_rd, s_din, s_strap, s_opt_a, s_opt_b} = pins.sync;

  clie_sync #(.W(14)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .port(pins)
  );

  logic [7:0] text_mem [0:127];
  logic [7:0] glyph_mem [0:63];
  logic [7:0] icon_mem [0:15];

  clie_pkg::clie_state_t state_q, state_d;
  clie_pkg::clie_sel_t sel_q, sel_d;
  logic [17:0] cnt_q, cnt_d;
  logic strobe_prev_q, strobe_prev_d, nib_wait_q, nib_wait_d;
  logic [3:0] nib_q, nib_d;
  logic [7:0] rdbuf_q, rdbuf_d, dout_d;
  logic reload_q, reload_d, follow_q, follow_d, disp_q, disp_d;
  logic cur_q, cur_d, blink_q, blink_d, tall_sel_q, tall_sel_d;
  logic bias_sel_q, bias_sel_d, blink_ph_q, blink_ph_d;
  logic [7:0] blink_div_q, blink_div_d;
  logic [6:0] ac_d;
  logic [5:0] shift_d;
  logic busy_d, oe_d, bus8_d, two_d, page_d, inc_d;
  logic edge_s, byte_done, read_first, cmd_acc, wr_acc, rd_acc, stat_rd;
  logic [7:0] byte_v, read_v;
  logic mem_we;
  clie_pkg::clie_sel_t mem_sel;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;

  // one step of the address counter with line wrap
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input clie_pkg::clie_sel_t s,
                                           input logic two, input logic tall1);
    logic [6:0] r;
    logic [6:0] lim;
    r = up ? a + 7'h01 : a - 7'h01;
    lim = tall1 ? `CLIE_LINE1_END : `CLIE_ONE_END;
    case (s)
      clie_pkg::CLIE_GLYPH: r = {1'b0, r[5:0]};
      clie_pkg::CLIE_ICON: r = {3'h0, r[3:0]};
      default: begin
        if (two) begin
          // line one flows into line two
          if (up && a == `CLIE_LINE1_END) r = `CLIE_LINE2_BEG;
          else if (up && a >= `CLIE_LINE2_END) r = 7'h00;
          else if (!up && a == `CLIE_LINE2_BEG) r = `CLIE_LINE1_END;
          else if (!up && a == 7'h00) r = `CLIE_LINE2_END;
        end else begin
          if (up && a >= lim) r = 7'h00;
          else if (!up && a == 7'h00) r = lim;
        end
      end
    endcase
    return r;
  endfunction

  // rotate the display window by one column
  function automatic logic [5:0] rot_shift(input logic [5:0] s, input logic left);
    logic [5:0] r;
    r = left ? ((s >= `CLIE_SHIFT_MAX) ? 6'h00 : s + 6'h01)
             : ((s == 6'h00) ? `CLIE_SHIFT_MAX : s - 6'h01);
    return r;
  endfunction

  // next values: host transfers, decode, execution timing
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    nib_wait_d = nib_wait_q;
    nib_d = nib_q;
    rdbuf_d = rdbuf_q;
    dout_d = bus_dout_q;
    reload_d = 1'b0;
    follow_d = follow_q;
    disp_d = disp_q;
    cur_d = cur_q;
    blink_d = blink_q;
    tall_sel_d = tall_sel_q;
    bias_sel_d = bias_sel_q;
    ac_d = address_counter_q;
    shift_d = display_shift_q;
    busy_d = busy_indicator_q;
    bus8_d = bus_width_select_q;
    two_d = two_line_q;
    page_d = instruction_page_select_q;
    inc_d = entry_inc_q;
    mem_we = 1'b0;
    mem_sel = sel_q;
    mem_addr = address_counter_q;
    strobe_prev_d = s_strobe;
    edge_s = s_strobe & ~strobe_prev_q;
    oe_d = s_strobe & s_rd;
    byte_v = bus_width_select_q ? s_din : {nib_q, s_din[7:4]};
    byte_done = edge_s & ~s_rd & (bus_width_select_q | nib_wait_q);
    read_first = edge_s & s_rd & (bus_width_select_q | ~nib_wait_q);
    mem_wdata = byte_v;
    // status word, data reads come from prefetch
    read_v = s_rs ? rdbuf_q : {busy_indicator_q, address_counter_q};
    stat_rd = read_first & ~s_rs;
    // nothing but status is taken while busy
    cmd_acc = byte_done & ~s_rs & ~busy_indicator_q;
    wr_acc = byte_done & s_rs & ~busy_indicator_q;
    rd_acc = read_first & s_rs & ~busy_indicator_q;
    if (edge_s && !bus_width_select_q) begin
      if (s_rd) begin
        nib_wait_d = ~nib_wait_q;
        nib_d = read_v[3:0];
        dout_d = nib_wait_q ? {nib_q, 4'h0} : {read_v[7:4], 4'h0};
      end else begin
        nib_wait_d = ~nib_wait_q;
        nib_d = s_din[7:4];
      end
    end else if (read_first) begin
      dout_d = read_v;
    end
    // execution time count, busy until done
    if (state_q != clie_pkg::CLIE_IDLE) begin
      cnt_d = cnt_q + 18'h00001;
      if (state_q == clie_pkg::CLIE_CLEAR) begin
        if (cnt_q <= `CLIE_FILL_LAST) begin
          mem_we = 1'b1;
          mem_sel = clie_pkg::CLIE_TEXT;
          mem_addr = cnt_q[6:0];
          mem_wdata = `CLIE_SPACE;
        end
        if (cnt_q == 18'(CLEAR_CYC - 1)) begin
          state_d = clie_pkg::CLIE_IDLE;
          busy_d = 1'b0;
        end
      end else if (cnt_q == 18'(EXEC_CYC - 1)) begin
        state_d = clie_pkg::CLIE_IDLE;
        busy_d = 1'b0;
      end
    end
    if (cmd_acc || wr_acc || rd_acc) begin
      state_d = clie_pkg::CLIE_EXEC;
      cnt_d = 18'h00000;
      busy_d = 1'b1;
    end
    // data write into the selected memory
    if (wr_acc) begin
      mem_we = 1'b1;
      if (follow_q && sel_q == clie_pkg::CLIE_TEXT) begin
        shift_d = rot_shift(display_shift_q, entry_inc_q);
      end
    end
    // step after every data access, sign from entry mode
    if (wr_acc || rd_acc) begin
      ac_d = step_addr(address_counter_q, entry_inc_q, sel_q, two_line_q, tall_font_q);
      reload_d = 1'b1;
    end
    if (cmd_acc) begin
      casez (byte_v)
        // text address set, ranges kept by stepping
        8'b1???????: begin
          ac_d = byte_v[6:0];
          sel_d = clie_pkg::CLIE_TEXT;
          reload_d = 1'b1;
        end
        8'b01??????: begin
          // glyph address on page zero, symbol address on page one
          if (!instruction_page_select_q) begin
            ac_d = {1'b0, byte_v[5:0]};
            sel_d = clie_pkg::CLIE_GLYPH;
            reload_d = 1'b1;
          end else if (byte_v[5:4] == 2'h0) begin
            ac_d = {3'h0, byte_v[3:0]};
            sel_d = clie_pkg::CLIE_ICON;
            reload_d = 1'b1;
          end
        end
        8'b001?????: begin
          // function set fields, test bit ignored
          bus8_d = byte_v[`CLIE_FN_BUS8];
          two_d = byte_v[`CLIE_FN_LINE2];
          tall_sel_d = byte_v[`CLIE_FN_TALL];
          page_d = byte_v[`CLIE_FN_PAGE];
          nib_wait_d = 1'b0;
        end
        8'b0001????: begin
          if (instruction_page_select_q) begin
            bias_sel_d = byte_v[`CLIE_BS_BIT];
          end else if (byte_v[`CLIE_SH_SCREEN]) begin
            shift_d = rot_shift(display_shift_q, ~byte_v[`CLIE_SH_RIGHT]);
          end else begin
            ac_d = step_addr(address_counter_q, byte_v[`CLIE_SH_RIGHT],
                             clie_pkg::CLIE_TEXT, two_line_q, tall_font_q);
          end
        end
        8'b00001???: begin
          disp_d = byte_v[`CLIE_DC_DISP];
          cur_d = byte_v[`CLIE_DC_CUR];
          blink_d = byte_v[`CLIE_DC_BLINK];
        end
        8'b000001??: begin
          inc_d = byte_v[`CLIE_EM_INC];
          follow_d = byte_v[`CLIE_EM_FOLLOW];
        end
        8'b0000001?: begin
          ac_d = 7'h00;
          shift_d = 6'h00;
        end
        8'b00000001: begin
          ac_d = 7'h00;
          shift_d = 6'h00;
          inc_d = 1'b1;
          sel_d = clie_pkg::CLIE_TEXT;
          state_d = clie_pkg::CLIE_CLEAR;
        end
        default: begin
          ac_d = address_counter_q;
        end
      endcase
    end
    // prefetch the byte at the counter for the next data read
    if (reload_q) begin
      case (sel_q)
        clie_pkg::CLIE_GLYPH: rdbuf_d = glyph_mem[address_counter_q[5:0]];
        clie_pkg::CLIE_ICON: rdbuf_d = icon_mem[address_counter_q[3:0]];
        default: rdbuf_d = text_mem[address_counter_q];
      endcase
    end
    blink_div_d = blink_div_q + 8'h01;
    blink_ph_d = (blink_div_q == 8'hFF) ? ~blink_ph_q : blink_ph_q;
  end

  // memory write port
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      case (mem_sel)
        clie_pkg::CLIE_GLYPH: glyph_mem[mem_addr[5:0]] <= mem_wdata;
        clie_pkg::CLIE_ICON: icon_mem[mem_addr[3:0]] <= mem_wdata;
        default: text_mem[mem_addr] <= mem_wdata;
      endcase
    end
  end

  // state registers and outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= clie_pkg::CLIE_IDLE;
      sel_q <= clie_pkg::CLIE_TEXT;
      cnt_q <= 18'h00000;
      strobe_prev_q <= 1'b0;
      nib_wait_q <= 1'b0;
      nib_q <= 4'h0;
      rdbuf_q <= 8'h00;
      reload_q <= 1'b0;
      follow_q <= 1'b0;
      disp_q <= 1'b0;
      cur_q <= 1'b0;
      blink_q <= 1'b0;
      tall_sel_q <= 1'b0;
      bias_sel_q <= 1'b0;
      blink_ph_q <= 1'b0;
      blink_div_q <= 8'h00;
      bus_dout_q <= 8'h00;
      bus_dout_oe_q <= 1'b0;
      busy_indicator_q <= 1'b0;
      address_counter_q <= 7'h00;
      display_shift_q <= 6'h00;
      panel_on_q <= 1'b0;
      cursor_show_q <= 1'b0;
      cursor_all_dots_q <= 1'b0;
      bus_width_select_q <= `CLIE_RST_BUS8;
      two_line_q <= 1'b0;
      tall_font_q <= 1'b0;
      instruction_page_select_q <= 1'b0;
      bias_quarter_q <= 1'b0;
      entry_inc_q <= `CLIE_RST_INC;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      strobe_prev_q <= strobe_prev_d;
      nib_wait_q <= nib_wait_d;
      nib_q <= nib_d;
      rdbuf_q <= rdbuf_d;
      reload_q <= reload_d;
      follow_q <= follow_d;
      disp_q <= disp_d;
      cur_q <= cur_d;
      blink_q <= blink_d;
      tall_sel_q <= tall_sel_d;
      bias_sel_q <= bias_sel_d;
      blink_ph_q <= blink_ph_d;
      blink_div_q <= blink_div_d;
      bus_dout_q <= dout_d;
      bus_dout_oe_q <= oe_d;
      busy_indicator_q <= busy_d;
      address_counter_q <= ac_d;
      display_shift_q <= shift_d;
      panel_on_q <= disp_q;
      cursor_show_q <= disp_q & cur_q;
      cursor_all_dots_q <= disp_q & blink_q & blink_ph_q;
      bus_width_select_q <= bus8_d;
      two_line_q <= two_d;
      // tall font only with strap low and one line
      tall_font_q <= tall_sel_q & ~s_strap & ~two_line_q;
      instruction_page_select_q <= page_d;
      bias_quarter_q <= bias_sel_q & ~(s_opt_a & s_opt_b);
      entry_inc_q <= inc_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_clear_go;
    cmd_acc && byte_v == 8'h01;
  endsequence
  sequence s_home_go;
    cmd_acc && byte_v[7:1] == 7'h01;
  endsequence

  chk_clear_home: assert property (s_clear_go |=> address_counter_q == 7'h00
    && entry_inc_q && display_shift_q == 6'h00 && busy_indicator_q)
    else $error("clear did not home");
  chk_home_only: assert property (s_home_go |=> address_counter_q == 7'h00
    && display_shift_q == 6'h00) else $error("home did not reset address");
  chk_busy_hold: assert property ((cmd_acc || wr_acc) |=> busy_indicator_q [*8])
    else $error("busy dropped early");
  chk_status_word: assert property (stat_rd && bus_width_select_q
    |=> bus_dout_q == {$past(busy_indicator_q), $past(address_counter_q)})
    else $error("status word wrong");
  chk_glyph_step: assert property (wr_acc && sel_q == clie_pkg::CLIE_GLYPH
    && entry_inc_q |=> address_counter_q[5:0] == $past(address_counter_q[5:0]) + 6'h01)
    else $error("glyph address did not step");
  chk_line_wrap: assert property (cmd_acc && byte_v[7:2] == 6'h05
    && two_line_q && !instruction_page_select_q && address_counter_q == 7'h27
    |=> address_counter_q == 7'h40)
    else $error("cursor did not enter line two");
  chk_read_noshift: assert property (rd_acc |=> $stable(display_shift_q))
    else $error("read shifted display");
  chk_shift_keeps: assert property (cmd_acc && byte_v[7:3] == 5'h03
    && !instruction_page_select_q |=> $stable(address_counter_q))
    else $error("display shift moved address");
  chk_bias_ext: assert property (s_opt_a && s_opt_b |=> !bias_quarter_q)
    else $error("bias select not overridden");
  chk_blank_panel: assert property (!disp_q |=> !panel_on_q)
    else $error("panel lit while display off");
endmodule

// ### hdl/clie_defs.svh
/*
  Constants of the character display instruction executor: field positions,
  reset values, address limits and execution times.
  Assumes a 200 MHz ref_clk; included by the executor files.
*/
`ifndef CLIE_DEFS_SVH
`define CLIE_DEFS_SVH
// clock period and execution times, in ns
`define CLIE_CLK_NS 5
`define CLIE_T_EXEC_NS 26300
`define CLIE_T_CLEAR_NS 1080000
// function set field positions
`define CLIE_FN_BUS8 4
`define CLIE_FN_LINE2 3
`define CLIE_FN_TALL 2
`define CLIE_FN_PAGE 0
// entry mode, display control, shift and bias field positions
`define CLIE_EM_INC 1
`define CLIE_EM_FOLLOW 0
`define CLIE_DC_DISP 2
`define CLIE_DC_CUR 1
`define CLIE_DC_BLINK 0
`define CLIE_SH_SCREEN 3
`define CLIE_SH_RIGHT 2
`define CLIE_BS_BIT 3
// reset values
`define CLIE_RST_BUS8 1'h1
`define CLIE_RST_INC 1'h1
// text memory codes and limits
`define CLIE_SPACE 8'h20
`define CLIE_LINE1_END 7'h27
`define CLIE_LINE2_BEG 7'h40
`define CLIE_LINE2_END 7'h67
`define CLIE_ONE_END 7'h4F
`define CLIE_SHIFT_MAX 6'h27
`define CLIE_FILL_LAST 18'h0007F
`endif

// ### hdl/clie_pkg.sv
/*
  Types of the character display instruction executor.
  Assumes nothing of its surroundings.
*/
package clie_pkg;
  // executor state
  typedef enum logic [1:0] {
    CLIE_IDLE = 2'b00,
    CLIE_EXEC = 2'b01,
    CLIE_CLEAR = 2'b10
  } clie_state_t;
  // memory picked by the latest address set
  typedef enum logic [1:0] {
    CLIE_TEXT = 2'b00,
    CLIE_GLYPH = 2'b01,
    CLIE_ICON = 2'b10
  } clie_sel_t;
endpackage

// ### hdl/clie_sync_if.sv
/*
  Carrier between the pin synchroniser and the executor.
  Assumes one clock domain on the synchroniser side.
*/
`timescale 1ns/1ps
interface clie_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_mp (input raw, output sync);
  modport user_mp (output raw, input sync);
endinterface

// ### hdl/clie_sync.sv
/*
  Two-stage synchroniser for asynchronous pins, width set by parameter W.
  Assumes ref_clk and an asynchronous active-high rst.
*/
`timescale 1ns/1ps
module clie_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  clie_sync_if.sync_mp port
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      hold_q <= '0;
    end else begin
      meta_q <= port.raw;
      hold_q <= meta_q;
    end
  end

  assign port.sync = hold_q;
endmodule

// ### verif/clie_host_model.sv
/*
  Host processor model for the display instruction executor: byte and nibble
  transfers on the parallel bus, and status polling until busy clears.
  Assumes the executor samples the pins through a synchroniser on ref_clk.
*/
`timescale 1ns/1ps
module clie_host_model (
  input wire logic ref_clk,
  output logic bus_strobe,
  output logic register_select_line,
  output logic bus_read,
  output logic [7:0] bus_din,
  input wire logic [7:0] bus_dout_q
);
  logic nib_q; // host copy of the bus width, 1 = nibble transfers

  // idle bus at time zero
  initial begin
    bus_strobe = 1'h0;
    register_select_line = 1'h0;
    bus_read = 1'h0;
    bus_din = 8'h00;
    nib_q = 1'h0;
  end

  // one strobe: set up, 4 cycles high, 4 low, then the released lines drift
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d);
    @(posedge ref_clk);
    register_select_line <= rs;
    bus_read <= rw;
    bus_din <= d;
    @(posedge ref_clk);
    bus_strobe <= 1'h1;
    repeat (4) @(posedge ref_clk);
    bus_strobe <= 1'h0;
    repeat (4) @(posedge ref_clk);
    bus_din <= ~d;
  endtask

  // nibble mode sends upper half first
  task automatic send(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    if (nib_q) begin
      pulse(rs, rw, {d[7:4], ~d[7:4]});
      q[7:4] = bus_dout_q[7:4];
      pulse(rs, rw, {d[3:0], ~d[3:0]});
      q[3:0] = bus_dout_q[7:4];
    end else begin
      pulse(rs, rw, d);
      q = bus_dout_q;
    end
    if (!rs && !rw && d[7:5] == 3'h1) begin
      nib_q = !d[4];
    end
  endtask

  // poll status until busy clears, bounded
  task automatic wait_ready(output logic ok);
    logic [7:0] s;
    ok = 1'h0;
    for (int i = 0; i < 100 && !ok; i++) begin
      send(1'h0, 1'h1, 8'h00, s);
      ok = !s[7];
    end
  endtask
endmodule

// ### verif/clie_top_tb_top.sv
/*
  Self-checking bench of the display instruction executor, one task per scenario.
  Assumes the host model polls busy between instructions; short execution counts.
*/
`timescale 1ns/1ps
module clie_top_tb_top;
  logic ref_clk, rst, bus_strobe, register_select_line, bus_read, bus_dout_oe_q;
  logic instruction_set_strap, follower_option_a, follower_option_b, busy_indicator_q;
  logic panel_on_q, cursor_show_q, cursor_all_dots_q, bus_width_select_q, two_line_q;
  logic tall_font_q, instruction_page_select_q, bias_quarter_q, entry_inc_q;
  logic [7:0] bus_din, bus_dout_q, q;
  logic [6:0] address_counter_q;
  logic [5:0] display_shift_q;
  wire [7:0] acx = {1'h0, address_counter_q};
  wire [7:0] shx = {2'h0, display_shift_q};
  int num_errors = 0;
  int samples_checked = 0;
  int oe_cycles = 0;

  // executor with short execution counts
  clie_top #(.EXEC_CYC(16), .CLEAR_CYC(200)) u_dut (
    .ref_clk, .rst, .bus_strobe, .register_select_line, .bus_read, .bus_din,
    .instruction_set_strap, .follower_option_a, .follower_option_b, .bus_dout_q,
    .bus_dout_oe_q, .busy_indicator_q, .address_counter_q, .display_shift_q, .panel_on_q,
    .cursor_show_q, .cursor_all_dots_q, .bus_width_select_q, .two_line_q, .tall_font_q,
    .instruction_page_select_q, .bias_quarter_q, .entry_inc_q
  );
  // host processor on the far side of the bus
  clie_host_model u_host (
    .ref_clk, .bus_strobe, .register_select_line, .bus_read, .bus_din, .bus_dout_q
  );

  // free-running clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // read enable cycles seen on the bus
  always @(posedge ref_clk) begin
    if (bus_dout_oe_q) begin
      oe_cycles <= oe_cycles + 1;
    end
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // wait for busy to clear, a hang ends the run
  task automatic ready();
    logic ok;
    u_host.wait_ready(ok);
    if (!ok) begin
      num_errors++;
      end_sim();
    end
  endtask

  // command, data write and data read, each followed by the busy wait
  task automatic cmd(input logic [7:0] c);
    u_host.send(1'h0, 1'h0, c, q);
    ready();
  endtask
  task automatic wr(input logic [7:0] d);
    u_host.send(1'h1, 1'h0, d, q);
    ready();
  endtask
  task automatic rd();
    u_host.send(1'h1, 1'h1, 8'h00, q);
    ready();
  endtask

  // outputs straight after reset
  task automatic t_reset();
    check({6'h00, busy_indicator_q, panel_on_q}, 8'h00);
    check({6'h00, bus_width_select_q, entry_inc_q}, 8'h03);
    check(acx, 8'h00);
  endtask

  // writes, busy status, refused command, reads back
  task automatic t_write_read();
    int oe_seen;
    cmd(8'h38);
    cmd(8'h85);
    check(acx, 8'h05);
    u_host.send(1'h1, 1'h0, 8'h41, q);
    u_host.send(1'h0, 1'h1, 8'h00, q);
    check(q, 8'h86);
    ready();
    u_host.send(1'h1, 1'h0, 8'h42, q);
    cmd(8'h80);
    check(acx, 8'h07);
    cmd(8'h85);
    oe_seen = oe_cycles;
    u_host.send(1'h1, 1'h1, 8'h00, q);
    check(8'(oe_cycles - oe_seen), 8'h04);
    ready();
    check(q, 8'h41);
    rd();
    check(q, 8'h42);
    check(acx, 8'h07);
  endtask

  // step direction and follow shift
  task automatic t_entry();
    cmd(8'h90);
    cmd(8'h04);
    wr(8'h31);
    check(acx, 8'h0F);
    cmd(8'h07);
    wr(8'h32);
    check(acx, 8'h10);
    check(shx, 8'h01);
    rd();
    check(shx, 8'h01);
    cmd(8'h05);
    wr(8'h33);
    check(acx, 8'h10);
    check(shx, 8'h00);
  endtask

  // cursor and display shift, line wrap, return home
  task automatic t_shift();
    cmd(8'h06);
    cmd(8'hA7);
    cmd(8'h14);
    check(acx, 8'h40);
    cmd(8'h10);
    check(acx, 8'h27);
    cmd(8'h18);
    cmd(8'h18);
    check(shx, 8'h02);
    check(acx, 8'h27);
    cmd(8'h1C);
    check(shx, 8'h01);
    cmd(8'h02);
    check(acx, 8'h00);
    check(shx, 8'h00);
    cmd(8'h85);
    rd();
    check(q, 8'h41);
  endtask

  // glyph memory address, write and read back
  task automatic t_glyph();
    cmd(8'h07);
    cmd(8'h43);
    check(acx, 8'h03);
    wr(8'h1F);
    check(acx, 8'h04);
    check(shx, 8'h00);
    cmd(8'h43);
    rd();
    check(q, 8'h1F);
    cmd(8'h85);
    rd();
    check(q, 8'h41);
    cmd(8'h06);
  endtask

  // every display control code, then blink phase
  task automatic t_display();
    logic a;
    logic [2:0] dc;
    for (int i = 0; i < 8; i++) begin
      dc = 3'(i);
      cmd(8'h08 | 8'(i));
      check({6'h00, panel_on_q, cursor_show_q}, {6'h00, dc[2], dc[2] & dc[1]});
    end
    a = cursor_all_dots_q;
    // 256 cycles, half a blink period, hold exactly one phase change
    repeat (256) @(posedge ref_clk);
    check({7'h00, cursor_all_dots_q}, {7'h00, ~a});
    cmd(8'h0E);
    repeat (300) @(posedge ref_clk);
    check({7'h00, cursor_all_dots_q}, 8'h00);
  endtask

  // extension page: bias select, shift code not decoded
  task automatic t_page();
    cmd(8'h39);
    check({7'h00, instruction_page_select_q}, 8'h01);
    cmd(8'h18);
    check({7'h00, bias_quarter_q}, 8'h01);
    // external bias straps override the bias select
    follower_option_a <= 1'h1;
    follower_option_b <= 1'h1;
    repeat (4) @(posedge ref_clk);
    check({7'h00, bias_quarter_q}, 8'h00);
    follower_option_a <= 1'h0;
    follower_option_b <= 1'h0;
    repeat (4) @(posedge ref_clk);
    check({7'h00, bias_quarter_q}, 8'h01);
    cmd(8'h14);
    check({7'h00, bias_quarter_q}, 8'h00);
    check(acx, 8'h06);
    check(shx, 8'h00);
    cmd(8'h38);
  endtask

  // tall one-line font wraps at 27H, normal one-line at 4FH, strap forces normal font
  task automatic t_font();
    cmd(8'h34);
    check({6'h00, two_line_q, tall_font_q}, 8'h01);
    cmd(8'hA7);
    cmd(8'h14);
    check(acx, 8'h00);
    cmd(8'h30);
    cmd(8'hCF);
    cmd(8'h14);
    check(acx, 8'h00);
    instruction_set_strap <= 1'h1;
    cmd(8'h34);
    check({7'h00, tall_font_q}, 8'h00);
    instruction_set_strap <= 1'h0;
    cmd(8'h38);
  endtask

  // nibble bus: address set and read, then back to bytes
  task automatic t_nibble();
    cmd(8'h28);
    check({7'h00, bus_width_select_q}, 8'h00);
    cmd(8'h85);
    check(acx, 8'h05);
    rd();
    check(q, 8'h41);
    cmd(8'h38);
    check({7'h00, bus_width_select_q}, 8'h01);
  endtask

  // clear from decrement mode with the display shifted
  task automatic t_clear();
    cmd(8'h04);
    cmd(8'h18);
    cmd(8'h01);
    check(acx, 8'h00);
    check(shx, 8'h00);
    check({7'h00, entry_inc_q}, 8'h01);
    cmd(8'h85);
    rd();
    check(q, 8'h20);
  endtask

  // reset, scenarios, verdict
  initial begin
    rst = 1'h1;
    instruction_set_strap = 1'h0;
    follower_option_a = 1'h0;
    follower_option_b = 1'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    t_reset();
    t_write_read();
    t_entry();
    t_shift();
    t_glyph();
    t_display();
    t_page();
    t_font();
    t_nibble();
    t_clear();
    end_sim();
  end
endmodule
